// >>> deser_cfg.svh
`ifndef DESER_CFG_SVH
`define DESER_CFG_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
// System clock rate in kHz.
`define CLK_SYS_KHZ 250000
// Lowest pixel clock in normal and in low-frequency mode, kHz.
`define PCLK_MIN_KHZ_NORMAL 15000
`define PCLK_MIN_KHZ_LOWFREQ 5000
// Pixel clock periods without an edge before lock is declared lost.
`define STALL_PERIODS 2
// Longest wait rounds down, so the timeout never exceeds the figure.
`define STALL_CYC_NORMAL ((`CLK_SYS_KHZ * `STALL_PERIODS) / `PCLK_MIN_KHZ_NORMAL)
`define STALL_CYC_LOWFREQ ((`CLK_SYS_KHZ * `STALL_PERIODS) / `PCLK_MIN_KHZ_LOWFREQ)
// Consecutive pixel clock edges needed to complete the lock sequence.
`define LOCK_EDGES 64
// System cycles per LVDS bit period.
`define BIT_DIV 2

// ****************************************************************
// Frame layout
// ****************************************************************
`define LANE_BITS 7
`define LANE_COUNT 4
`define FRAME_BITS 28
`define PIX_BITS 27
// Clock lane pattern, first bit sent is the MSB: two high, three low, two high.
`define CLK_LANE_PATTERN 7'h63
// Pixel word field positions.
`define PIX_RED_LSB 0
`define PIX_GREEN_LSB 8
`define PIX_BLUE_LSB 16
`define PIX_HSYNC 24
`define PIX_VSYNC 25
`define PIX_DE 26

// ****************************************************************
// Audio master clock
// ****************************************************************
// Ratio code used while software has not taken over the field.
`define MCLK_CODE_DEFAULT 3'h1

`endif

// >>> deser_output_chk.sv
`timescale 1ns/1ps
// Watches output modes, the clock lane shape and the audio clock settings.
module deser_output_chk #(
  parameter int BIT_DIV = 2
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic SERIAL_ACTIVE,
  input wire logic CLK_LANE_OSC_EN,
  input wire logic OVERRUN,
  input wire logic OUTPUT_DRIVE_ENABLE,
  input wire logic OUTPUT_SLEEP_STATE_SELECT,
  input wire logic BACKWARD_COMPAT_MODE,
  input wire logic AUDIO_PLL_EN,
  input wire logic MCLK_RATIO_OVERRIDE,
  input wire logic [2:0] MCLK_RATIO_SELECT,
  input wire logic LOCK,
  input wire logic PAR_OE,
  input wire logic [26:0] PIX_OUT,
  input wire logic LVDS_CLOCK_OUT,
  input wire logic [3:0] LVDS_DATA_LANE,
  input wire logic LVDS_DATA_OE,
  input wire logic LINE_RATE_X4,
  input wire logic MCLK_ENABLE,
  input wire logic [2:0] MCLK_RATIO_CODE
);
  logic lvl_q;
  logic [7:0] run_q;
  wire output_drive_enable = OUTPUT_DRIVE_ENABLE;
  wire oss = OUTPUT_SLEEP_STATE_SELECT;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // Run length of the clock lane level; it saturates so long idle gaps stay legal.
  always_ff @(posedge CLK_SYS) begin
    lvl_q <= RST_B & LVDS_CLOCK_OUT;
    if (!RST_B || LVDS_CLOCK_OUT != lvl_q) run_q <= 8'h01;
    else if (run_q != 8'hff) run_q <= run_q + 8'h01;
  end
  logic [3:0] ctl_q;
  logic [7:0] quiet_q;
  // Mode, input, oscillation and overrun changes may cut a frame, so runs are judged once settled.
  always_ff @(posedge CLK_SYS) begin
    ctl_q <= {output_drive_enable, oss, SERIAL_ACTIVE, CLK_LANE_OSC_EN};
    if (!RST_B || OVERRUN || ctl_q != {output_drive_enable, oss, SERIAL_ACTIVE, CLK_LANE_OSC_EN}) quiet_q <= 8'h00;
    else if (quiet_q != 8'hff) quiet_q <= quiet_q + 8'h01;
  end
  // Mode checks allow for the input synchronisers before judging the pins.
  a_park_low: assert property (
    (!output_drive_enable && !oss) [*6] |-> PAR_OE && LVDS_DATA_OE && !(|PIX_OUT) && !(|LVDS_DATA_LANE))
    else $error("park low not held");
  a_park_hiz: assert property (
    (!output_drive_enable && oss) [*6] |-> !PAR_OE && !LVDS_DATA_OE) else $error("park undriven not held");
  a_sleep_low: assert property (
    (output_drive_enable && !oss) [*6] |-> !LOCK && !(|PIX_OUT) && !(|LVDS_DATA_LANE)) else $error("sleep low broken");
  a_static_data: assert property (
    (output_drive_enable && oss && !SERIAL_ACTIVE) [*8] |-> !(|PIX_OUT)) else $error("static data not low");
  a_lock_drop: assert property (
    (!SERIAL_ACTIVE) [*8] |-> !LOCK) else $error("lock kept on static input");
  a_clk_high: assert property (
    (quiet_q >= 8'hc8 && lvl_q && !LVDS_CLOCK_OUT) |-> (run_q == 2 * BIT_DIV || run_q == 4 * BIT_DIV))
    else $error("clock lane high run wrong");
  a_clk_low: assert property (
    (quiet_q >= 8'hc8 && !lvl_q && LVDS_CLOCK_OUT) |-> run_q >= 3 * BIT_DIV)
    else $error("clock lane low run short");
  a_code_sel: assert property (
    (MCLK_RATIO_OVERRIDE && $stable(MCLK_RATIO_SELECT)) [*5] |-> MCLK_RATIO_CODE == MCLK_RATIO_SELECT)
    else $error("ratio code not selected");
  a_code_dflt: assert property (
    (!MCLK_RATIO_OVERRIDE) [*5] |-> MCLK_RATIO_CODE == 3'h1) else $error("ratio default wrong");
  a_mclk_off: assert property (
    (!AUDIO_PLL_EN) [*5] |-> !MCLK_ENABLE) else $error("master clock not off");
  a_backward_compat_mode_rate: assert property (
    BACKWARD_COMPAT_MODE [*5] |-> !LINE_RATE_X4) else $error("rate multiplied in compat mode");
endmodule : deser_output_chk

bind deser_output_ctrl deser_output_chk #(.BIT_DIV(BIT_DIV)) chk_u (.*);

// >>> deser_output_ctrl.sv
`timescale 1ns/1ps
`include "deser_cfg.svh"
module deser_output_ctrl #(
  parameter int LOCK_EDGES = `LOCK_EDGES,
  parameter int BIT_DIV = `BIT_DIV,
  parameter int BUF_DEPTH = 2
) (
  input wire logic CLK_SYS,
  input wire logic RST_B,
  input wire logic PCLK_IN,
  input wire logic SERIAL_ACTIVE,
  input wire logic PASS_IN,
  input wire logic [`PIX_BITS-1:0] PIX_IN,
  input wire logic [7:0] AUX_IN,
  input wire logic OUTPUT_DRIVE_ENABLE,
  input wire logic OUTPUT_SLEEP_STATE_SELECT,
  input wire logic BIT_MAP_SELECT_PIN,
  input wire logic BIT_MAP_SELECT_REG,
  input wire logic BIT_MAP_FROM_REG,
  input wire logic LOW_FREQ_MODE_PIN,
  input wire logic LOW_FREQ_MODE_REG,
  input wire logic LOW_FREQ_FROM_REG,
  input wire logic BACKWARD_COMPAT_MODE,
  input wire logic COLOR_18BIT,
  input wire logic CLK_LANE_OSC_EN,
  input wire logic AUDIO_PLL_EN,
  input wire logic MCLK_RATIO_OVERRIDE,
  input wire logic [2:0] MCLK_RATIO_SELECT,
  output logic LOCK,
  output logic LOCK_OE,
  output logic PASS,
  output logic PASS_OE,
  output logic [`PIX_BITS-1:0] PIX_OUT,
  output logic [7:0] AUX_OUT,
  output logic PAR_OE,
  output logic LVDS_CLOCK_OUT,
  output logic [`LANE_COUNT-1:0] LVDS_DATA_LANE,
  output logic LVDS_CLOCK_OE,
  output logic LVDS_DATA_OE,
  output logic LOW_FREQ_MODE_ACTIVE,
  output logic LINE_RATE_X4,
  output logic MCLK_ENABLE,
  output logic [2:0] MCLK_RATIO_CODE,
  output logic OVERRUN
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int SW = 1 + 1 + 1 + `PIX_BITS + 8 + 16;

  logic [SW-1:0] raw;
  logic [SW-1:0] meta_q;
  logic [SW-1:0] sync_q;
  logic pclk_s;
  logic active_s;
  logic pass_s;
  logic [`PIX_BITS-1:0] pix_s;
  logic [7:0] aux_s;
  logic oen_s;
  logic oss_s;
  logic map_pin_s;
  logic map_reg_s;
  logic map_src_s;
  logic lf_pin_s;
  logic lf_reg_s;
  logic lf_src_s;
  logic backward_compat_mode_s;
  logic c18_s;
  logic osc_s;
  logic pll_s;
  logic ovr_s;
  logic [2:0] ratio_s;

  assign raw = {PCLK_IN, SERIAL_ACTIVE, PASS_IN, PIX_IN, AUX_IN, OUTPUT_DRIVE_ENABLE,
                OUTPUT_SLEEP_STATE_SELECT, BIT_MAP_SELECT_PIN, BIT_MAP_SELECT_REG, BIT_MAP_FROM_REG,
                LOW_FREQ_MODE_PIN, LOW_FREQ_MODE_REG, LOW_FREQ_FROM_REG, BACKWARD_COMPAT_MODE,
                COLOR_18BIT, CLK_LANE_OSC_EN, AUDIO_PLL_EN, MCLK_RATIO_OVERRIDE, MCLK_RATIO_SELECT};

  // Every pin passes two flip-flops; only the second stage is read.
  // No reset here, so the mode pins are already seen while power-down is held.
  always_ff @(posedge CLK_SYS) begin
    meta_q <= raw;
    sync_q <= meta_q;
  end

  assign {pclk_s, active_s, pass_s, pix_s, aux_s, oen_s, oss_s, map_pin_s, map_reg_s, map_src_s,
          lf_pin_s, lf_reg_s, lf_src_s, backward_compat_mode_s, c18_s, osc_s, pll_s, ovr_s, ratio_s} = sync_q;

  // ****************************************************************
  // Pixel clock edge detection
  // ****************************************************************
  logic pclk_prev_q;
  logic pclk_rise;

  // The pixel clock is sampled, not used as a clock, so it needs 3+ samples per phase.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      pclk_prev_q <= 1'b1; // A pin already high at release gives no false edge.
    end else begin
      pclk_prev_q <= pclk_s;
    end
  end

  assign pclk_rise = pclk_s & ~pclk_prev_q;

  // ****************************************************************
  // Low-frequency mode and line rate
  // ****************************************************************
  logic lf_q;
  logic [7:0] stall_limit;

  // Mode is caught only while power-down is held, so a change needs a reset cycle.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      lf_q <= lf_src_s ? lf_reg_s : lf_pin_s;
    end
  end

  // The slower range needs a longer silence before the input counts as static.
  assign stall_limit = lf_q ? 8'(`STALL_CYC_LOWFREQ) : 8'(`STALL_CYC_NORMAL);

  // Range and line-rate indications for the serial front end.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      LOW_FREQ_MODE_ACTIVE <= 1'b0;
      LINE_RATE_X4 <= 1'b0;
    end else begin
      LOW_FREQ_MODE_ACTIVE <= lf_q;
      LINE_RATE_X4 <= lf_q & ~backward_compat_mode_s;
    end
  end

  // ****************************************************************
  // Lock acquisition
  // ****************************************************************
  deser_pkg::lock_state_t lock_state_q;
  logic [$clog2(LOCK_EDGES+1)-1:0] edge_cnt_q;
  logic [7:0] stall_q;
  logic stalled;

  assign stalled = (stall_q >= stall_limit) | ~active_s;

  // Silence counter: cleared by every rising pixel clock edge.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      stall_q <= '0;
    end else if (pclk_rise) begin
      stall_q <= '0;
    end else if (stall_q != 8'hFF) begin
      stall_q <= 8'(stall_q + 1'b1);
    end
  end

  // Acquisition starts at release of power-down and falls back on silence.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      lock_state_q <= deser_pkg::LOCK_ACQUIRE;
      edge_cnt_q <= '0;
    end else begin
      case (lock_state_q)
        deser_pkg::LOCK_ACQUIRE: begin
          if (stalled) begin
            edge_cnt_q <= '0;
          end else if (pclk_rise) begin
            if (edge_cnt_q == ($bits(edge_cnt_q))'(LOCK_EDGES - 1)) begin
              lock_state_q <= deser_pkg::LOCK_HELD;
            end
            edge_cnt_q <= ($bits(edge_cnt_q))'(edge_cnt_q + 1'b1);
          end
        end
        deser_pkg::LOCK_HELD: begin
          if (stalled) begin
            lock_state_q <= deser_pkg::LOCK_ACQUIRE;
            edge_cnt_q <= '0;
          end
        end
        default: begin
          lock_state_q <= deser_pkg::LOCK_ACQUIRE;
        end
      endcase
    end
  end

  logic locked;
  assign locked = (lock_state_q == deser_pkg::LOCK_HELD);

  // ****************************************************************
  // Output mode selection
  // ****************************************************************
  deser_pkg::out_mode_t out_mode;

  always_comb begin
    if (!oen_s) begin
      out_mode = oss_s ? deser_pkg::OUT_PARK_HIZ : deser_pkg::OUT_PARK_LOW;
    end else if (!oss_s || !locked || stalled) begin
      out_mode = deser_pkg::OUT_SLEEP_HOLD;
    end else begin
      out_mode = deser_pkg::OUT_LIVE;
    end
  end

  // ****************************************************************
  // Pixel capture, buffer and frame building
  // ****************************************************************
  logic [`FRAME_BITS-1:0] frame_word;
  logic map_msb;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [`FRAME_BITS-1:0] buf_out_data;
  logic [7:0] red;
  logic [7:0] grn;
  logic [7:0] blu;
  logic [5:0] r6;
  logic [5:0] g6;
  logic [5:0] b6;
  logic [6:0] lane3;

  assign map_msb = map_src_s ? map_reg_s : map_pin_s;
  assign red = pix_s[`PIX_RED_LSB +: 8];
  assign grn = pix_s[`PIX_GREEN_LSB +: 8];
  assign blu = pix_s[`PIX_BLUE_LSB +: 8];

  // Lane 3 carries the two colour bits of each channel that lanes 0-2 leave out, except in 18-bit mode where it carries zeros.
  always_comb begin
    if (c18_s) begin
      r6 = red[7:2];
      g6 = grn[7:2];
      b6 = blu[7:2];
      lane3 = '0;
    end else if (map_msb) begin
      r6 = red[5:0];
      g6 = grn[5:0];
      b6 = blu[5:0];
      lane3 = {1'b0, blu[7:6], grn[7:6], red[7:6]};
    end else begin
      r6 = red[7:2];
      g6 = grn[7:2];
      b6 = blu[7:2];
      lane3 = {1'b0, blu[1:0], grn[1:0], red[1:0]};
    end
  end

  // Frame order: lane 3 | lane 2 | lane 1 | lane 0, seven bits each.
  assign frame_word = {lane3,
                       pix_s[`PIX_DE], pix_s[`PIX_VSYNC], pix_s[`PIX_HSYNC], b6[5:2],
                       b6[1:0], g6[5:1],
                       g6[0], r6};

  // One word per pixel edge while locked; the buffer absorbs framer stalls.
  pix_buf2 #(
    .WIDTH(`FRAME_BITS),
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .in_valid(pclk_rise & locked),
    .in_ready(buf_in_ready),
    .in_data(frame_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  logic osc_q;
  logic fr_clk;
  logic [`LANE_COUNT-1:0] fr_data;

  // Oscillation permit is cleared by reset and follows its pin afterwards.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_s;
    end
  end

  lvds_framer #(
    .BIT_DIV(BIT_DIV)
  ) u_framer (
    .clk(CLK_SYS),
    .rst_b(RST_B),
    .frame_valid(buf_out_valid),
    .frame_ready(buf_out_ready),
    .frame_data(buf_out_data),
    .idle_run(osc_q & stalled & (out_mode == deser_pkg::OUT_SLEEP_HOLD) & ~oss_s),
    .clk_lane(fr_clk),
    .data_lane(fr_data)
  );

  // A pixel edge that finds the buffer full is reported; the stream cannot be stalled.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      OVERRUN <= 1'b0;
    end else begin
      OVERRUN <= pclk_rise & locked & ~buf_in_ready;
    end
  end

  // ****************************************************************
  // Pin drivers
  // ****************************************************************
  // Lock: undriven before lock with drive enable low; high once locked unless drive enable is high with sleep select low; low otherwise.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      LOCK <= 1'b0;
      LOCK_OE <= 1'b0;
    end else begin
      LOCK_OE <= locked | oen_s;
      LOCK <= locked & (~oen_s | oss_s);
    end
  end

  // Pass, parallel data and lanes follow the output mode.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      PASS <= 1'b0;
      PASS_OE <= 1'b0;
      PIX_OUT <= '0;
      AUX_OUT <= '0;
      PAR_OE <= 1'b0;
      LVDS_CLOCK_OUT <= 1'b0;
      LVDS_DATA_LANE <= '0;
      LVDS_CLOCK_OE <= 1'b0;
      LVDS_DATA_OE <= 1'b0;
    end else begin
      case (out_mode)
        deser_pkg::OUT_PARK_HIZ: begin
          PASS_OE <= 1'b0;
          PAR_OE <= 1'b0;
          LVDS_CLOCK_OE <= 1'b0;
          LVDS_DATA_OE <= 1'b0;
        end
        deser_pkg::OUT_LIVE: begin
          PASS_OE <= 1'b1;
          PAR_OE <= 1'b1;
          LVDS_CLOCK_OE <= 1'b1;
          LVDS_DATA_OE <= 1'b1;
          PASS <= pass_s;
          if (pclk_rise) begin
            PIX_OUT <= pix_s;
            AUX_OUT <= aux_s;
          end
          LVDS_CLOCK_OUT <= fr_clk;
          LVDS_DATA_LANE <= fr_data;
        end
        deser_pkg::OUT_SLEEP_HOLD: begin
          PASS_OE <= 1'b1;
          PAR_OE <= 1'b1;
          LVDS_CLOCK_OE <= 1'b1;
          LVDS_DATA_OE <= 1'b1;
          // Pass keeps its last value only when sleep select is high, on static input or before lock.
          if (!oss_s) begin
            PASS <= 1'b0;
          end
          PIX_OUT <= '0;
          AUX_OUT <= '0;
          LVDS_DATA_LANE <= '0;
          LVDS_CLOCK_OUT <= fr_clk & osc_q & ~oss_s & stalled;
        end
        default: begin
          PASS_OE <= 1'b1;
          PAR_OE <= 1'b1;
          LVDS_CLOCK_OE <= 1'b1;
          LVDS_DATA_OE <= 1'b1;
          PASS <= 1'b0;
          PIX_OUT <= '0;
          AUX_OUT <= '0;
          LVDS_CLOCK_OUT <= 1'b0;
          LVDS_DATA_LANE <= '0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Audio master clock control
  // ****************************************************************
  // Default ratio is twice the bit clock until software overrides it.
  always_ff @(posedge CLK_SYS) begin
    if (!RST_B) begin
      MCLK_ENABLE <= 1'b0;
      MCLK_RATIO_CODE <= `MCLK_CODE_DEFAULT;
    end else begin
      MCLK_ENABLE <= pll_s;
      MCLK_RATIO_CODE <= ovr_s ? ratio_s : `MCLK_CODE_DEFAULT;
    end
  end

endmodule : deser_output_ctrl

// >>> deser_pkg.sv
// ****************************************************************
// Shared types
// ****************************************************************
package deser_pkg;

  // Lock state of the clock recovery loop.
  typedef enum logic {
    LOCK_ACQUIRE,
    LOCK_HELD
  } lock_state_t;

  // Output behaviour picked from the drive enable and sleep state select.
  typedef enum logic [1:0] {
    OUT_PARK_LOW,
    OUT_PARK_HIZ,
    OUT_SLEEP_HOLD,
    OUT_LIVE
  } out_mode_t;

endpackage : deser_pkg

// >>> lvds_framer.sv
`timescale 1ns/1ps
`include "deser_cfg.svh"
// Shifts one 28-bit frame out over four data lanes and the clock lane.
module lvds_framer #(
  parameter int BIT_DIV = `BIT_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic frame_valid,
  output logic frame_ready,
  input wire logic [`FRAME_BITS-1:0] frame_data,
  input wire logic idle_run,
  output logic clk_lane,
  output logic [`LANE_COUNT-1:0] data_lane
);

  localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;

  logic [DW-1:0] div_q;
  logic bit_en;
  logic [2:0] bit_q;
  logic busy_q;
  logic load;
  logic [`LANE_BITS-1:0] clk_sr_q;
  logic [`LANE_BITS-1:0] lane_sr_q [`LANE_COUNT];

  // Bit period enable from a divider of the system clock.
  assign bit_en = (div_q == '0);
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_q <= '0;
    end else begin
      div_q <= (div_q == DW'(BIT_DIV - 1)) ? '0 : DW'(div_q + 1'b1);
    end
  end

  // A frame is taken at a bit boundary when idle or in the last bit of the one before,
  // so back-to-back pixels give frames with no gap between them.
  assign load = ~busy_q | (bit_q == 3'(`LANE_BITS - 1));
  assign frame_ready = bit_en & load;

  // Bit counter: seven periods per frame, one frame per buffered pixel.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bit_q <= '0;
      busy_q <= 1'b0;
    end else if (bit_en) begin
      if (load) begin
        busy_q <= frame_valid | idle_run;
        bit_q <= '0;
      end else begin
        bit_q <= 3'(bit_q + 1'b1);
      end
    end
  end

  // Clock lane repeats its 4:3 pattern aligned to every frame.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clk_sr_q <= '0;
    end else if (bit_en) begin
      if (load && (frame_valid || idle_run)) begin
        clk_sr_q <= `CLK_LANE_PATTERN;
      end else if (busy_q) begin
        clk_sr_q <= {clk_sr_q[`LANE_BITS-2:0], 1'b0};
      end
    end
  end

  // Data lane shifters; an idle frame carries zeros.
  for (genvar g = 0; g < `LANE_COUNT; g++) begin : g_lane
    always_ff @(posedge clk) begin
      if (!rst_b) begin
        lane_sr_q[g] <= '0;
      end else if (bit_en) begin
        if (load) begin
          lane_sr_q[g] <= frame_valid ? frame_data[g*`LANE_BITS +: `LANE_BITS] : '0;
        end else begin
          lane_sr_q[g] <= {lane_sr_q[g][`LANE_BITS-2:0], 1'b0};
        end
      end
    end
    assign data_lane[g] = busy_q & lane_sr_q[g][`LANE_BITS-1];
  end

  assign clk_lane = busy_q & clk_sr_q[`LANE_BITS-1];

endmodule : lvds_framer

// >>> pix_buf2.sv
`timescale 1ns/1ps
// Two-entry buffer in the pixel path, valid and ready on both sides.
module pix_buf2 #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage write.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end

endmodule : pix_buf2

// >>> pix_src.sv
`timescale 1ns/1ps
// Upstream source model: pixel clock and a fixed pixel word.
module pix_src (
  input wire logic run,
  input wire logic fast,
  output logic pclk,
  output logic [26:0] pix
);
  // The clock stands low while not running; the fast rate outpaces the framer on purpose.
  initial begin
    pclk = 1'b0;
    pix = 27'h000_0003;
    forever begin
      if (run) begin
        #(fast ? 16 : 40) pclk = 1'b1;
        #(fast ? 16 : 40) pclk = 1'b0;
      end else #4;
    end
  end
endmodule : pix_src

// >>> test_deser_output_ctrl.sv
`timescale 1ns/1ps
// Drives the output controller from a pixel source and judges its pins.
module test_deser_output_ctrl;
  logic CLK_SYS = 1'b0, RST_B = 1'b0, SERIAL_ACTIVE = 1'b0, PASS_IN = 1'b0, COLOR_18BIT = 1'b0;
  logic OUTPUT_DRIVE_ENABLE = 1'b0, OUTPUT_SLEEP_STATE_SELECT = 1'b1, CLK_LANE_OSC_EN = 1'b0;
  logic BIT_MAP_SELECT_PIN = 1'b0, BIT_MAP_SELECT_REG = 1'b0, BIT_MAP_FROM_REG = 1'b0;
  logic LOW_FREQ_MODE_PIN = 1'b0, LOW_FREQ_MODE_REG = 1'b0, LOW_FREQ_FROM_REG = 1'b0;
  logic BACKWARD_COMPAT_MODE = 1'b0, AUDIO_PLL_EN = 1'b1, MCLK_RATIO_OVERRIDE = 1'b0;
  logic run = 1'b0, fast = 1'b0, lane_p = 1'b0;
  logic [2:0] MCLK_RATIO_SELECT = 3'h0;
  logic [7:0] AUX_IN = 8'h5a;
  logic PCLK_IN, LOCK, LOCK_OE, PASS, PASS_OE, PAR_OE, LVDS_CLOCK_OUT, LVDS_CLOCK_OE, LVDS_DATA_OE;
  logic LOW_FREQ_MODE_ACTIVE, LINE_RATE_X4, MCLK_ENABLE, OVERRUN;
  logic [2:0] MCLK_RATIO_CODE;
  logic [7:0] AUX_OUT;
  logic [26:0] PIX_IN, PIX_OUT;
  logic [3:0] LVDS_DATA_LANE;
  int fails = 0, check_count = 0, tick = 0, rises = 0, l3_hi = 0, ovr = 0, mark;
  deser_output_ctrl #(.LOCK_EDGES(4)) dut_u (.*);
  pix_src src_u (.run(run), .fast(fast), .pclk(PCLK_IN), .pix(PIX_IN));
  // A 4 ns system clock.
  always #2 CLK_SYS = ~CLK_SYS;
  // Counts lane activity and drops; the cycle ceiling stops a hung run.
  always @(posedge CLK_SYS) begin
    lane_p <= LVDS_CLOCK_OUT;
    rises <= rises + (LVDS_CLOCK_OUT && !lane_p);
    l3_hi <= l3_hi + LVDS_DATA_LANE[3];
    ovr <= ovr + OVERRUN;
    tick++;
    if (tick == 20000) begin
      fails++;
      final_report();
    end
  end
  task cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask : cyc
  task chk(input string n, input logic [26:0] e, input logic [26:0] g);
    #1;
    check_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task setm(input logic [2:0] v);
    cyc(1);
    {OUTPUT_DRIVE_ENABLE, OUTPUT_SLEEP_STATE_SELECT, SERIAL_ACTIVE} <= v;
  endtask : setm
  task wait_lock();
    for (int i = 0; i < 400 && LOCK !== 1'b1; i++) @(posedge CLK_SYS);
  endtask : wait_lock
  task t_lock();
    cyc(10);
    chk("lock_oe", 27'h000_0000, LOCK_OE);
    chk("par_oe", 27'h000_0000, PAR_OE);
    setm(3'h7);
    {PASS_IN, run} <= 2'h3;
    chk("lock", 27'h000_0000, LOCK);
    wait_lock();
    chk("lock", 27'h000_0001, LOCK);
    cyc(60);
    chk("pix", 27'h000_0003, PIX_OUT);
    chk("aux", 27'h000_005a, AUX_OUT);
    @(posedge PCLK_IN);
    mark = rises;
    repeat (10) @(posedge PCLK_IN);
    chk("frames", 27'h000_0014, 27'(rises - mark));
    $display("test lock done");
  endtask : t_lock
  task t_map();
    for (int i = 0; i < 4; i++) begin
      cyc(1);
      {BIT_MAP_SELECT_PIN, COLOR_18BIT, BIT_MAP_SELECT_REG, BIT_MAP_FROM_REG} <= {i == 1, i == 2, i == 3, i == 3};
      cyc(60);
      mark = l3_hi;
      cyc(100);
      chk("lane3", 27'(i == 0), 27'(l3_hi != mark));
    end
    $display("test map done");
  endtask : t_map
  task t_static();
    setm(3'h6);
    PASS_IN <= 1'b0;
    cyc(20);
    chk("lock", 27'h000_0000, LOCK);
    chk("pass", 27'h000_0001, PASS);
    chk("pix", 27'h000_0000, PIX_OUT);
    setm(3'h4);
    CLK_LANE_OSC_EN <= 1'b1;
    cyc(10);
    mark = rises;
    cyc(100);
    chk("osc", 27'h000_0001, 27'(rises > mark));
    cyc(1);
    CLK_LANE_OSC_EN <= 1'b0;
    cyc(30);
    mark = rises;
    cyc(100);
    chk("osc", 27'h000_0000, 27'(rises > mark));
    $display("test static done");
  endtask : t_static
  task t_modes();
    setm(3'h7);
    wait_lock();
    for (int i = 0; i < 3; i++) begin
      setm({i == 2, i == 1, 1'b1});
      cyc(20);
      chk("oe", 27'({2{i != 1}}), 27'({PAR_OE, LVDS_DATA_OE}));
      chk("lock", 27'(i != 2), LOCK);
    end
    $display("test modes done");
  endtask : t_modes
  task t_overrun();
    setm(3'h7);
    wait_lock();
    mark = ovr;
    fast <= 1'b1;
    cyc(300);
    chk("ovr", 27'h000_0001, 27'(ovr > mark));
    fast <= 1'b0;
    cyc(100);
    mark = ovr;
    cyc(200);
    chk("ovr", 27'h000_0000, 27'(ovr > mark));
    chk("lock", 27'h000_0001, LOCK);
    $display("test overrun done");
  endtask : t_overrun
  task t_lf();
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      {RST_B, LOW_FREQ_MODE_PIN, LOW_FREQ_MODE_REG, LOW_FREQ_FROM_REG, BACKWARD_COMPAT_MODE} <= {1'b0, i == 0, i == 1, i == 1, 1'b0};
      cyc(16);
      RST_B <= 1'b1;
      cyc(8);
      chk("lf", 27'h000_0003, 27'({LOW_FREQ_MODE_ACTIVE, LINE_RATE_X4}));
      cyc(1);
      BACKWARD_COMPAT_MODE <= 1'b1;
      cyc(8);
      chk("lf", 27'h000_0002, 27'({LOW_FREQ_MODE_ACTIVE, LINE_RATE_X4}));
    end
    $display("test lf done");
  endtask : t_lf
  task t_mclk();
    cyc(1);
    MCLK_RATIO_OVERRIDE <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      cyc(1);
      MCLK_RATIO_SELECT <= 3'(c);
      cyc(8);
      chk("code", 27'(c), MCLK_RATIO_CODE);
    end
    chk("mclk", 27'h000_0001, MCLK_ENABLE);
    cyc(1);
    {MCLK_RATIO_OVERRIDE, AUDIO_PLL_EN} <= 2'h0;
    cyc(8);
    chk("code", 27'h000_0001, MCLK_RATIO_CODE);
    chk("mclk", 27'h000_0000, MCLK_ENABLE);
    $display("test mclk done");
  endtask : t_mclk
  task final_report();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report
  // Reset for 16 cycles, then the scenarios in turn.
  initial begin
    cyc(10);
    chk("oe", 27'h000_0000, {LOCK_OE, PASS_OE, PAR_OE, LVDS_CLOCK_OE, LVDS_DATA_OE});
    chk("code", 27'h000_0001, MCLK_RATIO_CODE);
    cyc(6);
    RST_B <= 1'b1;
    t_lock();
    t_map();
    t_static();
    t_modes();
    t_overrun();
    t_lf();
    t_mclk();
    final_report();
  end
endmodule : test_deser_output_ctrl
